// [hw/ssacr_dev.sv]
// Device end: conversion control, result registers and the three readout modes.
// Assumes all link inputs are asynchronous to mclk; each passes two flip-flops first.
`timescale 1ns/100ps
module ssacr_dev
	import ssacr_pkg::*;
#(
	parameter int CONV_CNT = CONV_CYCLES
)
(
	input wire logic mclk,
	input wire logic nrst,
	ssacr_if.dev link,
	input wire logic [ALL_W-1:0] ch_data,
	output logic hold_a,
	output logic hold_b,
	output logic range_wide
);
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic pend_a;
		logic pend_b;
		logic hold_a;
		logic hold_b;
		logic busy;
		logic range_wide;
		logic [15:0] conv_cnt;
		logic [ALL_W-1:0] res;
		logic [3:0] rd_idx;
		logic [4:0] fall_cnt;
		logic [SER_W-1:0] sh_a;
		logic [SER_W-1:0] sh_b;
		logic [15:0] db;
		logic [15:0] db_oe;
		logic flag;
		logic flag_oe;
	} ssacr_dev_t;

	ssacr_dev_t q_reg;
	ssacr_dev_t q_next;
	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] rise;
	logic [SYNC_W-1:0] fall;
	logic par_mode;
	logic byte_mode;
	logic ser_mode;
	logic cs_low;
	logic hi_byte;
	logic [RES_W-1:0] cur_word;
	// Idle pin levels: chip select and read strobe rest high, so reset must not fake a select
	localparam logic [SYNC_W-1:0] PIN_IDLE = (SYNC_W'(1) << I_CS) | (SYNC_W'(1) << I_RD);

	// Result word of one channel, channel one at the bottom
	function automatic logic [RES_W-1:0] word_of(input logic [ALL_W-1:0] r, input logic [2:0] i);
		word_of = r[i*RES_W +: RES_W];
	endfunction

	// ----------------------------------------
	// Pin vector and edge detection
	// ----------------------------------------
	// Edges only look at the second and third stages, never the first
	assign pins = {link.high_byte_first, link.byte_mode_select, link.interface_select, link.range_sel,
		link.rd_sclk, link.cs_n, link.reset_pulse, link.start_strobe_b, link.start_strobe_a};
	assign rise = q_reg.s2 & ~q_reg.s3;
	assign fall = ~q_reg.s2 & q_reg.s3;
	assign par_mode = ~q_reg.s2[I_IF];
	assign byte_mode = q_reg.s2[I_IF] & q_reg.s2[I_BYTE];
	assign ser_mode = q_reg.s2[I_IF] & ~q_reg.s2[I_BYTE];
	assign cs_low = ~q_reg.s2[I_CS];
	assign hi_byte = q_reg.rd_idx[0] ^ q_reg.s2[I_HBF];
	assign cur_word = word_of(q_reg.res, byte_mode ? q_reg.rd_idx[3:1] : q_reg.rd_idx[2:0]);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		q_next = q_reg;
		q_next.s1 = pins;
		q_next.s2 = q_reg.s1;
		q_next.s3 = q_reg.s2;
		// Range follows the pin with no gating, even mid-conversion
		q_next.range_wide = q_reg.s2[I_RNG];

		// Conversion start and busy
		if (!q_reg.busy)
		begin
			// Edges while busy fall outside this branch and are dropped
			if (rise[I_CA])
			begin
				q_next.pend_a = 1'b1;
				q_next.hold_a = 1'b1;
			end
			if (rise[I_CB])
			begin
				q_next.pend_b = 1'b1;
				q_next.hold_b = 1'b1;
			end
			if (q_next.pend_a && q_next.pend_b)
			begin
				q_next.busy = 1'b1;
				q_next.conv_cnt = '0;
				q_next.pend_a = 1'b0;
				q_next.pend_b = 1'b0;
			end
		end
		else if (q_reg.conv_cnt == 16'(CONV_CNT - 1))
		begin
			q_next.busy = 1'b0;
			q_next.res = ch_data;
			q_next.hold_a = 1'b0;
			q_next.hold_b = 1'b0;
			q_next.rd_idx = '0;
		end
		else
		begin
			q_next.conv_cnt = q_reg.conv_cnt + 16'h0001;
		end

		// Parallel and byte reads on the read strobe falling edge
		if (cs_low && fall[I_RD] && !ser_mode)
		begin
			q_next.flag = (q_reg.rd_idx == 4'h0);
			if (par_mode)
			begin
				q_next.db = cur_word;
				q_next.rd_idx = {1'b0, q_reg.rd_idx[2:0] + 3'h1};
			end
			else
			begin
				q_next.db = {8'h00, hi_byte ? cur_word[15:8] : cur_word[7:0]};
				q_next.rd_idx = q_reg.rd_idx + 4'h1;
			end
		end

		// Serial frame: load on cs fall, shift on clock rise
		if (ser_mode && fall[I_CS])
		begin
			q_next.sh_a = {word_of(q_reg.res, 3'h0), word_of(q_reg.res, 3'h1),
				word_of(q_reg.res, 3'h2), word_of(q_reg.res, 3'h3)};
			q_next.sh_b = {word_of(q_reg.res, 3'h4), word_of(q_reg.res, 3'h5),
				word_of(q_reg.res, 3'h6), word_of(q_reg.res, 3'h7)};
			q_next.flag = 1'b1;
			q_next.fall_cnt = '0;
		end
		else if (ser_mode && cs_low)
		begin
			if (rise[I_RD])
			begin
				q_next.sh_a = {q_reg.sh_a[SER_W-2:0], 1'b0};
				q_next.sh_b = {q_reg.sh_b[SER_W-2:0], 1'b0};
			end
			if (fall[I_RD] && q_reg.fall_cnt != 5'(FLAG_FALLS))
			begin
				q_next.fall_cnt = q_reg.fall_cnt + 5'h01;
				if (q_reg.fall_cnt == 5'(FLAG_FALLS - 1))
				begin
					q_next.flag = 1'b0;
				end
			end
		end
		if (ser_mode)
		begin
			q_next.db = '0;
			q_next.db[SER_A_BIT] = q_next.sh_a[SER_W-1];
			q_next.db[SER_B_BIT] = q_next.sh_b[SER_W-1];
		end

		// Output enables per mode
		if (par_mode)
		begin
			q_next.db_oe = {16{cs_low & ~q_reg.s2[I_RD]}};
		end
		else if (byte_mode)
		begin
			q_next.db_oe = {8'h00, {8{cs_low & ~q_reg.s2[I_RD]}}};
		end
		else
		begin
			q_next.db_oe = '0;
			q_next.db_oe[SER_A_BIT] = cs_low;
			q_next.db_oe[SER_B_BIT] = cs_low;
		end
		q_next.flag_oe = cs_low;

		// Reset pulse rising edge overrides the above except the enables, range and serial fall count
		if (rise[I_RST])
		begin
			q_next.busy = 1'b0;
			q_next.pend_a = 1'b0;
			q_next.pend_b = 1'b0;
			q_next.hold_a = 1'b0;
			q_next.hold_b = 1'b0;
			q_next.conv_cnt = '0;
			q_next.res = '0;
			q_next.sh_a = '0;
			q_next.sh_b = '0;
			q_next.db = '0;
			q_next.rd_idx = '0;
			q_next.flag = 1'b0;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			q_reg <= '0;
			q_reg.s1 <= PIN_IDLE;
			q_reg.s2 <= PIN_IDLE;
			q_reg.s3 <= PIN_IDLE;
		end
		else
		begin
			q_reg <= q_next;
		end
	end

	// Outputs straight from the state register
	assign link.busy = q_reg.busy;
	assign link.parallel_result_bus = q_reg.db;
	assign link.parallel_result_bus_oe = q_reg.db_oe;
	assign link.first_channel_flag = q_reg.flag;
	assign link.first_channel_flag_oe = q_reg.flag_oe;
	assign hold_a = q_reg.hold_a;
	assign hold_b = q_reg.hold_b;
	assign range_wide = q_reg.range_wide;
endmodule

// [hw/ssacr_host.sv]
// Host end: APB-controlled sequencer that resets, starts and reads the converter.
// Assumes the device end on the same link; link inputs are synchronised with two flip-flops.
`timescale 1ns/100ps
module ssacr_host
	import ssacr_pkg::*;
#(
	parameter int HALF = HALF_CYCLES
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ssacr_if.host link
);
	typedef struct packed {
		ssacr_st_t st;
		logic [7:0] tmr;
		logic [6:0] idx;
		logic [1:0] busy_s;
		logic [15:0] d1;
		logic [15:0] d2;
		logic [5:0] cfg;
		logic done;
		logic [ALL_W-1:0] res;
		logic [SER_W-1:0] sa;
		logic [SER_W-1:0] sb;
		logic cs_n;
		logic rd;
		logic strb;
		logic rstp;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ssacr_host_t;

	ssacr_host_t q_reg;
	ssacr_host_t q_next;
	logic wr_acc;
	logic [6:0] n_xfer;
	logic [2:0] widx;
	logic [RES_W-1:0] w_old;

	// ----------------------------------------
	// Decode and helpers
	// ----------------------------------------
	assign wr_acc = psel & penable & pwrite & q_reg.pready & ~q_reg.pslverr;
	assign n_xfer = !q_reg.cfg[C_IFSEL] ? 7'(N_PAR) : (q_reg.cfg[C_BYTE] ? 7'(N_BYTE) : 7'(N_SER));
	assign widx = q_reg.cfg[C_IFSEL] ? q_reg.idx[3:1] : q_reg.idx[2:0];
	assign w_old = q_reg.res[widx*RES_W +: RES_W];

	always_comb
	begin
		q_next = q_reg;
		q_next.busy_s = {q_reg.busy_s[0], link.busy};
		q_next.d1 = link.bus_level;
		q_next.d2 = q_reg.d1;

		// APB: answer decided in setup, pready high for the access cycle
		q_next.pready = psel & ~penable;
		q_next.pslverr = 1'b0;
		if (psel && !penable)
		begin
			q_next.prdata = '0;
			q_next.pslverr = (paddr[1:0] != 2'b00) || (paddr > A_LAST);
			if (paddr == A_CTRL)
			begin
				q_next.prdata[5:0] = q_reg.cfg;
			end
			else if (paddr == A_STAT)
			begin
				q_next.prdata[S_BUSY] = q_reg.busy_s[1];
				q_next.prdata[S_DONE] = q_reg.done;
				q_next.prdata[S_ACT] = (q_reg.st != ST_IDLE);
			end
			else if (paddr >= A_DATA && paddr <= A_LAST)
			begin
				q_next.prdata[RES_W-1:0] = q_reg.res[(paddr[5:2] - 4'h2)*RES_W +: RES_W];
			end
		end
		if (wr_acc && paddr == A_CTRL)
		begin
			q_next.cfg = pwdata[5:0];
		end
		// Writing one to the done bit clears it; a finishing frame below wins
		if (wr_acc && paddr == A_STAT && pwdata[S_DONE])
		begin
			q_next.done = 1'b0;
		end

		if (q_reg.tmr != 8'h00)
		begin
			q_next.tmr = q_reg.tmr - 8'h01;
		end
		case (q_reg.st)
			ST_IDLE:
			begin
				// Commands written outside idle stay in cfg and run once idle is reached
				if (q_reg.cfg[C_RESET])
				begin
					q_next.cfg[C_RESET] = 1'b0;
					q_next.rstp = 1'b1;
					q_next.tmr = 8'(RST_CYCLES);
					q_next.st = ST_RSTP;
				end
				else if (q_reg.cfg[C_START])
				begin
					q_next.cfg[C_START] = 1'b0;
					q_next.strb = 1'b1;
					q_next.tmr = 8'(STRB_CYCLES);
					q_next.st = ST_STRB;
				end
			end
			ST_RSTP:
			begin
				if (q_reg.tmr == 8'h00)
				begin
					q_next.rstp = 1'b0;
					q_next.st = ST_IDLE;
				end
			end
			ST_STRB:
			begin
				if (q_reg.tmr == 8'h00)
				begin
					q_next.strb = 1'b0;
					q_next.st = ST_WHI;
				end
			end
			ST_WHI:
			begin
				if (q_reg.busy_s[1])
				begin
					q_next.st = ST_WLO;
				end
			end
			ST_WLO:
			begin
				// Reading only after busy falls keeps every read clear of it
				if (!q_reg.busy_s[1])
				begin
					q_next.cs_n = 1'b0;
					q_next.idx = '0;
					q_next.tmr = 8'(HALF);
					q_next.st = ST_CSDN;
				end
			end
			ST_CSDN:
			begin
				if (q_reg.tmr == 8'h00)
				begin
					q_next.rd = 1'b0;
					q_next.tmr = 8'(HALF);
					q_next.st = ST_LOW;
				end
			end
			ST_LOW:
			begin
				if (q_reg.tmr == 8'h00)
				begin
					if (!q_reg.cfg[C_IFSEL])
					begin
						q_next.res[widx*RES_W +: RES_W] = q_reg.d2;
					end
					else if (q_reg.cfg[C_BYTE])
					begin
						q_next.res[widx*RES_W +: RES_W] = (q_reg.idx[0] ^ q_reg.cfg[C_HBF]) ?
							{q_reg.d2[7:0], w_old[7:0]} : {w_old[15:8], q_reg.d2[7:0]};
					end
					else
					begin
						q_next.sa = {q_reg.sa[SER_W-2:0], q_reg.d2[SER_A_BIT]};
						q_next.sb = {q_reg.sb[SER_W-2:0], q_reg.d2[SER_B_BIT]};
					end
					q_next.rd = 1'b1;
					q_next.tmr = 8'(HALF);
					q_next.st = ST_HIGH;
				end
			end
			ST_HIGH:
			begin
				if (q_reg.tmr == 8'h00)
				begin
					q_next.idx = q_reg.idx + 7'h01;
					q_next.tmr = 8'(HALF);
					if (q_reg.idx == n_xfer - 7'h01)
					begin
						q_next.cs_n = 1'b1;
						q_next.st = ST_CSUP;
					end
					else
					begin
						q_next.rd = 1'b0;
						q_next.st = ST_LOW;
					end
				end
			end
			ST_CSUP:
			begin
				if (q_reg.tmr == 8'h00)
				begin
					if (q_reg.cfg[C_IFSEL] && !q_reg.cfg[C_BYTE])
					begin
						for (int i = 0; i < 4; i++)
						begin
							q_next.res[i*RES_W +: RES_W] = q_reg.sa[(3-i)*RES_W +: RES_W];
							q_next.res[(i+4)*RES_W +: RES_W] = q_reg.sb[(3-i)*RES_W +: RES_W];
						end
					end
					q_next.done = 1'b1;
					q_next.st = ST_IDLE;
				end
			end
			default:
			begin
				q_next.st = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			q_reg <= '0;
			q_reg.cs_n <= 1'b1;
			q_reg.rd <= 1'b1;
		end
		else
		begin
			q_reg <= q_next;
		end
	end

	assign prdata = q_reg.prdata;
	assign pready = q_reg.pready;
	assign pslverr = q_reg.pslverr;
	assign link.start_strobe_a = q_reg.strb;
	assign link.start_strobe_b = q_reg.strb;
	assign link.reset_pulse = q_reg.rstp;
	assign link.range_sel = q_reg.cfg[C_RANGE];
	assign link.cs_n = q_reg.cs_n;
	assign link.rd_sclk = q_reg.rd;
	assign link.interface_select = q_reg.cfg[C_IFSEL];
	assign link.byte_mode_select = q_reg.cfg[C_BYTE];
	assign link.high_byte_first = q_reg.cfg[C_HBF];
endmodule

// [hw/ssacr_if.sv]
// Link between the converter device end and the host controller end.
// Assumes both ends run on mclk; three-state lines resolve here, floating lines read low.
`timescale 1ns/100ps
interface ssacr_if;
	logic start_strobe_a;
	logic start_strobe_b;
	logic reset_pulse;
	logic range_sel;
	logic cs_n;
	logic rd_sclk;
	logic interface_select;
	logic byte_mode_select;
	logic high_byte_first;
	logic busy;
	logic first_channel_flag;
	logic first_channel_flag_oe;
	logic [15:0] parallel_result_bus;
	logic [15:0] parallel_result_bus_oe;
	logic [15:0] bus_level;
	logic flag_level;
	// ----------------------------------------
	// Wire levels from the enables
	// ----------------------------------------
	assign bus_level = parallel_result_bus & parallel_result_bus_oe;
	assign flag_level = first_channel_flag & first_channel_flag_oe;
	modport dev(
		input start_strobe_a, start_strobe_b, reset_pulse, range_sel, cs_n, rd_sclk,
		input interface_select, byte_mode_select, high_byte_first,
		output busy, first_channel_flag, first_channel_flag_oe, parallel_result_bus, parallel_result_bus_oe
	);
	modport host(
		output start_strobe_a, start_strobe_b, reset_pulse, range_sel, cs_n, rd_sclk,
		output interface_select, byte_mode_select, high_byte_first,
		input busy, bus_level, flag_level
	);
endinterface

// [hw/ssacr_pkg.sv]
// Shared constants for the converter control and readout block.
// Assumes one 50 MHz clock (mclk) on both ends and a synchronous active-low reset.
package ssacr_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_NS = 20;
	localparam int CONV_TIME_NS = 4000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_PULSE_NS = 50;
	localparam int RST_CYCLES = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STRB_CYCLES = 4;
	localparam int HALF_CYCLES = 8;
	// ----------------------------------------
	// Result layout
	// ----------------------------------------
	localparam int N_CH = 8;
	localparam int RES_W = 16;
	localparam int ALL_W = N_CH * RES_W;
	localparam int SER_W = 4 * RES_W;
	localparam int N_PAR = 8;
	localparam int N_BYTE = 16;
	localparam int N_SER = 64;
	localparam int FLAG_FALLS = 16;
	localparam int SER_A_BIT = 7;
	localparam int SER_B_BIT = 8;
	// ----------------------------------------
	// Synchronised pin vector on the device
	// ----------------------------------------
	localparam int SYNC_W = 9;
	localparam int I_CA = 0;
	localparam int I_CB = 1;
	localparam int I_RST = 2;
	localparam int I_CS = 3;
	localparam int I_RD = 4;
	localparam int I_RNG = 5;
	localparam int I_IF = 6;
	localparam int I_BYTE = 7;
	localparam int I_HBF = 8;
	// ----------------------------------------
	// Controller registers (APB byte addresses)
	// ----------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_DATA = 8'h08;
	localparam logic [7:0] A_LAST = 8'h24;
	localparam int C_START = 0;
	localparam int C_RESET = 1;
	localparam int C_RANGE = 2;
	localparam int C_IFSEL = 3;
	localparam int C_BYTE = 4;
	localparam int C_HBF = 5;
	localparam int S_BUSY = 0;
	localparam int S_DONE = 1;
	localparam int S_ACT = 2;
	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_RSTP = 4'b0001,
		ST_STRB = 4'b0010,
		ST_WHI = 4'b0011,
		ST_WLO = 4'b0100,
		ST_CSDN = 4'b0101,
		ST_LOW = 4'b0110,
		ST_HIGH = 4'b0111,
		ST_CSUP = 4'b1000
	} ssacr_st_t;
endpackage

// [verif/ssacr_checker.sv]
// Assertion checker for the link between the converter device end and the host end.
// Assumes it sits beside the link interface and watches its signals on mclk.
`timescale 1ns/100ps
module ssacr_checker
#(
	parameter int CONV_CNT = 200
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic start_strobe_a,
	input wire logic start_strobe_b,
	input wire logic cs_n,
	input wire logic rd_sclk,
	input wire logic interface_select,
	input wire logic byte_mode_select,
	input wire logic busy,
	input wire logic first_channel_flag_oe,
	input wire logic [15:0] parallel_result_bus_oe,
	input wire logic flag_level
);
	logic [15:0] busy_cnt_reg;
	logic [4:0] fall_cnt_reg;
	logic [1:0] rd_cnt_reg;
	logic ser;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Serial frames only; mode pins are steady while a frame is open
	assign ser = interface_select && !byte_mode_select;
	// --------------------------------
	// Helper counters
	// --------------------------------
	// Busy length, clock falls in a frame, reads since the last conversion
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			busy_cnt_reg <= 16'h0000;
			fall_cnt_reg <= 5'h00;
			rd_cnt_reg <= 2'h0;
		end
		else
		begin
			busy_cnt_reg <= busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
			fall_cnt_reg <= cs_n ? 5'h00 : fall_cnt_reg + 5'($fell(rd_sclk));
			rd_cnt_reg <= busy ? 2'h0 : rd_cnt_reg + 2'($fell(rd_sclk) && !cs_n && rd_cnt_reg != 2'h3);
		end
	end
	// --------------------------------
	// Properties
	// --------------------------------
	sequence s_strobe;
		$rose(start_strobe_a) && start_strobe_b && !busy;
	endsequence
	sequence s_rd_fall;
		$fell(rd_sclk) && !cs_n && !ser;
	endsequence
	sequence s_ser_frame;
		$fell(cs_n) && ser;
	endsequence
	property p_busy_rise;
		s_strobe |-> !busy[*2] ##[2:4] busy;
	endproperty
	property p_busy_cause;
		$rose(busy) |-> $past(start_strobe_a, 3) && $past(start_strobe_b, 3);
	endproperty
	property p_busy_len;
		$fell(busy) |-> busy_cnt_reg == 16'(CONV_CNT);
	endproperty
	property p_oe_cause;
		$rose(|parallel_result_bus_oe) && !ser |-> !$past(cs_n, 2) && !$past(rd_sclk, 2);
	endproperty
	property p_oe_drop;
		$rose(rd_sclk) && !ser |-> ##[1:6] parallel_result_bus_oe == 16'h0000;
	endproperty
	property p_lanes;
		(|parallel_result_bus_oe) && interface_select
			|-> (parallel_result_bus_oe & (byte_mode_select ? 16'hFF00 : 16'hFE7F)) == 16'h0000;
	endproperty
	property p_ser_start;
		s_ser_frame |-> ##[3:6] (flag_level && parallel_result_bus_oe[7] && parallel_result_bus_oe[8]);
	endproperty
	property p_ser_end;
		$fell(rd_sclk) && !cs_n && ser && fall_cnt_reg == 5'h0F |-> ##[3:6] !flag_level;
	endproperty
	property p_flag_float;
		cs_n[*6] |-> !first_channel_flag_oe;
	endproperty
	property p_first_set;
		s_rd_fall ##0 rd_cnt_reg == 2'h0 |-> ##[3:6] flag_level;
	endproperty
	property p_first_clear;
		s_rd_fall ##0 rd_cnt_reg == 2'h1 |-> ##[3:6] !flag_level;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy late after start");
	a_busy_cause: assert property (p_busy_cause) else $error("busy without both strobes");
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven without select and read");
	a_oe_drop: assert property (p_oe_drop) else $error("bus still driven after read");
	a_lanes: assert property (p_lanes) else $error("wrong lines driven");
	a_ser_start: assert property (p_ser_start) else $error("serial frame start wrong");
	a_ser_end: assert property (p_ser_end) else $error("serial flag not cleared");
	a_flag_float: assert property (p_flag_float) else $error("flag driven while deselected");
	a_first_set: assert property (p_first_set) else $error("flag not set on first read");
	a_first_clear: assert property (p_first_clear) else $error("flag not cleared on second read");
endmodule

// [verif/tb_sim_sample_adc_conv_readout.sv]
// Self-checking bench: software drives the host end over APB, the host reads the device end.
// Assumes the package, link interface, both ends and the checker are compiled first.
`timescale 1ns/100ps
module tb_sim_sample_adc_conv_readout
	import ssacr_pkg::*;
;
	localparam int CONV_T = 40;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [ALL_W-1:0] ch_data = '0;
	logic hold_a;
	logic hold_b;
	logic range_wide;
	logic [31:0] seed = 32'h0000005F;
	int num_errors = 0;
	int n_tests = 0;
	ssacr_if lnk();
	// --------------------------------
	// Clock and instances
	// --------------------------------
	always #(CLK_NS / 2) mclk = ~mclk;
	// Short conversion keeps the run brief; the checker gets the same count
	ssacr_dev #(.CONV_CNT(CONV_T)) u_ssacr_dev (.mclk(mclk), .nrst(nrst), .link(lnk.dev), .ch_data(ch_data),
		.hold_a(hold_a), .hold_b(hold_b), .range_wide(range_wide));
	ssacr_host u_ssacr_host (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk.host));
	ssacr_checker #(.CONV_CNT(CONV_T)) u_ssacr_checker (.mclk(mclk), .nrst(nrst),
		.start_strobe_a(lnk.start_strobe_a), .start_strobe_b(lnk.start_strobe_b), .cs_n(lnk.cs_n),
		.rd_sclk(lnk.rd_sclk), .interface_select(lnk.interface_select), .byte_mode_select(lnk.byte_mode_select),
		.busy(lnk.busy), .first_channel_flag_oe(lnk.first_channel_flag_oe),
		.parallel_result_bus_oe(lnk.parallel_result_bus_oe), .flag_level(lnk.flag_level));
	// --------------------------------
	// Helpers
	// --------------------------------
	// Xorshift keeps the stimulus repeatable
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Result register holds one channel in its low half
	function automatic logic [31:0] exp_res(input logic [ALL_W-1:0] d, input int ch);
		return {16'h0000, d[ch * RES_W +: RES_W]};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		// Only the watchdog ends a wait that never sees pready
		while (pready !== 1'b1)
		begin
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// Poll a status bit with a bound so a stuck flag cannot hang the run
	task automatic wait_stat(input int b);
		logic [31:0] r = '0;
		logic e;
		int n = 0;
		while (r[b] !== 1'b1 && n < 2000)
		begin
			apb(1'b0, A_STAT, 32'h00000000, r, e);
			n++;
		end
		if (n == 2000)
			num_errors++;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// --------------------------------
	// Tests
	// --------------------------------
	// Passes: parallel, byte high first, byte low first, serial, parallel after a reset pulse
	initial
	begin
		logic [31:0] r;
		logic e;
		logic [31:0] ctl;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		apb(1'b0, 8'h28, 32'h00000000, r, e);
		chk("unmapped err", 32'h00000001, {31'h0, e});
		apb(1'b1, 8'h02, 32'hFFFFFFFF, r, e);
		chk("unaligned err", 32'h00000001, {31'h0, e});
		for (int m = 0; m < 5; m++)
		begin
			r = rnd();
			ctl = {26'h0, m == 1, m == 1 || m == 2, m inside {[1:3]}, r[0], 2'b00};
			ch_data <= (m == 2) ? {ALL_W{1'b1}} : {rnd(), rnd(), rnd(), rnd()};
			if (m == 4)
			begin
				apb(1'b1, A_CTRL, ctl | 32'h00000002, r, e);
				repeat (20) @(posedge mclk);
			end
			apb(1'b1, A_CTRL, ctl | 32'h00000001, r, e);
			wait_stat(S_BUSY);
			chk("hold", 32'h00000003, {30'h0, hold_b, hold_a});
			chk("range", {31'h0, ctl[C_RANGE]}, {31'h0, range_wide});
			wait_stat(S_DONE);
			for (int c = 0; c < N_CH; c++)
			begin
				apb(1'b0, A_DATA + 8'(4 * c), 32'h00000000, r, e);
				chk("result", exp_res(ch_data, c), r);
			end
			apb(1'b1, A_STAT, 32'h00000002, r, e);
			apb(1'b0, A_STAT, 32'h00000000, r, e);
			chk("done clear", 32'h00000000, {31'h0, r[S_DONE]});
			$display("test %0d done", m);
		end
		finish_test();
	end
	// Watchdog well beyond the five passes
	initial
	begin
		#1000000;
		num_errors++;
		finish_test();
	end
endmodule
